// >>> test_weigher_zero_tare_setup_and_motion.sv
// Purpose: directed test of setup, save and motion behaviour
// Assumes: sample source model on the weight port
// Notes: short millisecond keeps the stable wait brief
`timescale 1ns/10ps
// ****************************************
// testbench
// ****************************************
module test_weigher_zero_tare_setup_and_motion
  import wzts_pkg::*;
#(parameter int CYC = 10);
  logic clk_sys;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic signed [31:0] load = 32'sh0000_01F4;
  logic signed [31:0] weight_in;
  logic weight_valid;
  logic nv_wr;
  logic [1:0] nv_kind;
  logic [19:0] nv_zero_window;
  logic stable;
  logic [31:0] r;
  logic [19:0] win_seen = 20'h00000;
  int nv_cnt [4] = '{0, 0, 0, 0};
  int fail_count = 0;
  int total_checks = 0;
  int n;
  // device and sample source
  wzts_core #(.CYC_PER_MS(CYC)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .weight_in(weight_in), .weight_valid(weight_valid), .range_return(1'b0), .nv_wr(nv_wr),
    .nv_kind(nv_kind), .nv_cal_zero(), .nv_cal_span(), .nv_zero_window(nv_zero_window),
    .nv_tare(), .nv_cur_zero(), .stable(stable));
  wzts_weight_src #(.PERIOD(8)) u_src (.clk_sys(clk_sys), .sys_rst(sys_rst), .load(load),
    .weight_in(weight_in), .weight_valid(weight_valid));
  // 25 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // count store pulses by kind, keep the saved window
  always @(posedge clk_sys)
  begin
    if (nv_wr === 1'b1)
    begin
      nv_cnt[nv_kind]++;
      if (nv_kind === WZTS_NV_GROUP)
        win_seen <= nv_zero_window;
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang;
    fail_count++;
    $display("mismatch wait expected answer seen none");
    stop_test();
  endtask
  // one classic Wishbone cycle, released after ack is sampled
  task automatic bus(input logic [7:0] adr, input logic we, input logic [31:0] dat,
    output logic [31:0] rdat);
    int k;
    k = 0;
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      k++;
      if (k > 20)
        hang();
    end
    while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  // params, command, then status {unlocked, done, error}
  task automatic run(input wzts_op_t op, input logic q, input logic [31:0] a,
    input logic [31:0] b, input logic [2:0] exp);
    bus(WZTS_ADR_PARAM_A, 1'b1, a, r);
    bus(WZTS_ADR_PARAM_B, 1'b1, b, r);
    bus(WZTS_ADR_CMD, 1'b1, {24'h000000, q, 2'h0, op}, r);
    bus(WZTS_ADR_STATUS, 1'b0, 32'h0000_0000, r);
    chk("result", {29'h0, exp}, {29'h0, r[10:8]});
  endtask
  task automatic qry(input wzts_op_t op, input logic [31:0] a, input logic [7:0] tag,
    input logic [2:0] exp);
    run(op, 1'b1, 32'h0000_0000, 32'h0000_0000, exp);
    bus(WZTS_ADR_REPLY_A, 1'b0, 32'h0000_0000, r);
    chk("reply", a, r);
    bus(WZTS_ADR_REPLY_TAG, 1'b0, 32'h0000_0000, r);
    if (tag != 8'h00)
      chk("tag", {24'h000000, tag}, r);
  endtask
  task automatic flag(input string what, input int pos, input logic exp);
    bus(WZTS_ADR_STATUS, 1'b0, 32'h0000_0000, r);
    chk(what, {31'h0, exp}, {31'h0, r[pos]});
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    flag("stable", 0, 1'b0);
    qry(WZTS_OP_ZERO_WIN, 32'h0000_0000, 8'h00, 3'h2);
    qry(WZTS_OP_INIT_BAND, 32'h0000_0000, 8'h00, 3'h2);
    qry(WZTS_OP_TARE_POL, 32'h0000_0000, 8'h00, 3'h2);
    qry(WZTS_OP_TARE_PERS, 32'h0000_0000, WZTS_TAG_T, 3'h2);
    qry(WZTS_OP_ZERO_PERS, 32'h0000_0000, WZTS_TAG_Z, 3'h2);
    qry(WZTS_OP_ABS_ZERO, 32'h0000_0000, WZTS_TAG_Z, 3'h2);
    qry(WZTS_OP_ABS_GAIN, WZTS_GAIN_SIG_RST, WZTS_TAG_G, 3'h2);
    bus(WZTS_ADR_REPLY_B, 1'b0, 32'h0000_0000, r);
    chk("gain count", WZTS_GAIN_CNT_RST, r);
    qry(WZTS_OP_MOT_BAND, {16'h0000, WZTS_MOTION_BAND_RST}, 8'h00, 3'h2);
    qry(WZTS_OP_STAB_MS, {16'h0000, WZTS_STABLE_MS_RST}, 8'h00, 3'h2);
    bus(8'h40, 1'b0, 32'h0000_0000, r);
    chk("unmapped", 32'h0000_0000, r);
    $display("test defaults done");
    run(WZTS_OP_ZERO_WIN, 1'b0, 32'h0000_0064, 32'h0000_0000, 3'h3);
    qry(WZTS_OP_ZERO_WIN, 32'h0000_0000, 8'h00, 3'h2);
    run(WZTS_OP_SAVE, 1'b0, 32'h0000_0000, 32'h0000_0000, 3'h3);
    chk("group stores", 32'h0000_0000, nv_cnt[WZTS_NV_GROUP]);
    qry(WZTS_OP_UNLOCK, 32'h0000_0000, WZTS_TAG_E, 3'h2);
    run(WZTS_OP_UNLOCK, 1'b0, 32'h0000_0000, 32'h0000_0000, 3'h6);
    run(WZTS_OP_ZERO_WIN, 1'b0, 32'h000F_4240, 32'h0000_0000, 3'h7);
    run(WZTS_OP_ZERO_WIN, 1'b0, 32'h000F_423F, 32'h0000_0000, 3'h6);
    qry(WZTS_OP_ZERO_WIN, 32'h000F_423F, 8'h00, 3'h6);
    run(WZTS_OP_ABS_ZERO, 1'b0, 32'h0000_80E9, 32'h0000_0000, 3'h7);
    run(WZTS_OP_ABS_ZERO, 1'b0, 32'hFFFF_7F18, 32'h0000_0000, 3'h6);
    qry(WZTS_OP_ABS_ZERO, 32'hFFFF_7F18, WZTS_TAG_Z, 3'h6);
    run(WZTS_OP_TARE_POL, 1'b0, 32'h0000_0004, 32'h0000_0000, 3'h7);
    run(WZTS_OP_TARE_POL, 1'b0, 32'h0000_0002, 32'h0000_0000, 3'h6);
    run(WZTS_OP_ABS_GAIN, 1'b0, 32'h0000_2BC0, 32'h0000_1388, 3'h6);
    qry(WZTS_OP_ABS_GAIN, 32'h0000_2BC0, WZTS_TAG_G, 3'h6);
    run(WZTS_OP_TARE_PERS, 1'b0, 32'h0000_0001, 32'h0000_0000, 3'h6);
    run(WZTS_OP_SAVE, 1'b0, 32'h0000_0000, 32'h0000_0000, 3'h2);
    chk("group stores", 32'h0000_0001, nv_cnt[WZTS_NV_GROUP]);
    chk("saved window", 32'h000F_423F, {12'h000, win_seen});
    qry(WZTS_OP_UNLOCK, 32'h0000_0001, WZTS_TAG_E, 3'h2);
    $display("test setup done");
    run(WZTS_OP_SET_TARE, 1'b0, 32'h0000_0000, 32'h0000_0000, 3'h3);
    for (n = 0; stable !== 1'b1; n++)
    begin
      if (n > 1100 * CYC)
        hang();
      @(posedge clk_sys);
    end
    flag("stable", 0, 1'b1);
    run(WZTS_OP_SET_TARE, 1'b0, 32'h0000_0000, 32'h0000_0000, 3'h2);
    flag("tare active", 2, 1'b1);
    chk("tare stores", 32'h0000_0001, nv_cnt[WZTS_NV_TARE]);
    load <= 32'sh0000_1388;
    repeat (24) @(posedge clk_sys);
    flag("stable", 0, 1'b0);
    run(WZTS_OP_SET_ZERO, 1'b0, 32'h0000_0000, 32'h0000_0000, 3'h3);
    $display("test motion done");
    stop_test();
  end
endmodule

// >>> wzts_core.sv
// Purpose: setup, zero, tare, calibration-save and motion logic of a load cell
// Assumes: weight samples come from logic on clk_sys; NV storage engine outside
// Notes: commands run in the cycle that the Wishbone write is acknowledged
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module wzts_core
  import wzts_pkg::*;
#(
  parameter int CYC_PER_MS = WZTS_CYC_PER_MS,
  parameter logic signed [31:0] CAPACITY = 32'sd100000
)
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // weight samples
  input wire logic signed [31:0] weight_in,
  input wire logic weight_valid,
  input wire logic range_return,
  // nonvolatile write requests
  output logic nv_wr,
  output logic [1:0] nv_kind,
  output logic signed [31:0] nv_cal_zero,
  output logic signed [31:0] nv_cal_span,
  output logic [19:0] nv_zero_window,
  output logic signed [31:0] nv_tare,
  output logic signed [31:0] nv_cur_zero,
  // status
  output logic stable
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic signed [31:0] param_a;
    logic signed [31:0] param_b;
    logic [7:0] last_cmd;
    logic res_err;
    logic res_done;
    logic signed [31:0] reply_a;
    logic signed [31:0] reply_b;
    logic [7:0] reply_tag;
    logic unlocked;
    logic [15:0] access_counter;
    logic signed [31:0] cal_zero;
    logic signed [31:0] cal_span;
    logic signed [31:0] cur_zero;
    logic signed [31:0] tare;
    logic tare_active;
    logic zero_done;
    logic [19:0] zero_window_setting;
    logic [23:0] initial_zero_band;
    logic init_done;
    logic [1:0] tare_policy;
    logic tare_persist_flag;
    logic zero_persist_flag;
    logic signed [31:0] absolute_zero_mvv;
    logic signed [31:0] gain_sig;
    logic signed [31:0] gain_cnt;
    logic [15:0] motion_band;
    logic [15:0] stable_window_ms;
    logic signed [31:0] mot_ref;
    logic mot_seen;
    logic [31:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic signed [31:0] weight;
    logic nv_wr;
    logic [1:0] nv_kind;
  } wzts_state_t;

  wzts_state_t st_r;
  wzts_state_t st_nxt;

  // magnitude of a difference, used by the motion band, initial zero band and zero window checks
  function automatic logic signed [31:0] abs_diff(input logic signed [31:0] a,
                                                  input logic signed [31:0] b);
    logic signed [31:0] d;
    d = a - b;
    abs_diff = (d < 0) ? -d : d;
  endfunction

  // range check for a signed parameter
  function automatic logic in_lim(input logic signed [31:0] v,
                                  input logic signed [31:0] lo,
                                  input logic signed [31:0] hi);
    in_lim = (v >= lo) && (v <= hi);
  endfunction

  logic bus_req;
  logic is_stable;
  logic signed [31:0] zero_win_eff;
  logic signed [31:0] gross;
  wzts_op_t op;
  logic query;

  // ****************************************************************
  // decoded helpers
  // ****************************************************************
  assign bus_req = wb_cyc_i && wb_stb_i && !st_r.ack;
  assign op = wzts_op_t'(wb_dat_i[4:0]);
  assign query = wb_dat_i[WZTS_CMD_QUERY_BIT];
  assign gross = st_r.weight - st_r.cur_zero;
  // stable once the ms count has covered the window with no motion
  assign is_stable = st_r.mot_seen && (st_r.ms_cnt >= st_r.stable_window_ms);
  // zero window, default two percent of capacity
  assign zero_win_eff = (st_r.zero_window_setting == 20'h00000)
                        ? (CAPACITY * WZTS_ZERO_WIN_PCT) / WZTS_PCT_DIV
                        : {12'h000, st_r.zero_window_setting};

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.nv_wr = 1'b0;
    st_nxt.ack = 1'b0;
    // wishbone answer one cycle after the request, dropped the next cycle
    if (bus_req)
    begin
      st_nxt.ack = 1'b1;
      unique case (wb_adr_i)
        WZTS_ADR_CMD: st_nxt.dat = {24'h000000, st_r.last_cmd};
        WZTS_ADR_PARAM_A: st_nxt.dat = st_r.param_a;
        WZTS_ADR_PARAM_B: st_nxt.dat = st_r.param_b;
        WZTS_ADR_STATUS: st_nxt.dat = {21'h000000, st_r.unlocked, st_r.res_done,
                                       st_r.res_err, 5'h00, st_r.tare_active,
                                       st_r.zero_done, is_stable};
        WZTS_ADR_REPLY_A: st_nxt.dat = st_r.reply_a;
        WZTS_ADR_REPLY_B: st_nxt.dat = st_r.reply_b;
        WZTS_ADR_REPLY_TAG: st_nxt.dat = {24'h000000, st_r.reply_tag};
        WZTS_ADR_GROSS: st_nxt.dat = gross;
        WZTS_ADR_NET: st_nxt.dat = gross - st_r.tare;
        default: st_nxt.dat = 32'h00000000;
      endcase
    end
    // parameter writes
    if (bus_req && wb_we_i && wb_adr_i == WZTS_ADR_PARAM_A && (&wb_sel_i))
      st_nxt.param_a = wb_dat_i;
    if (bus_req && wb_we_i && wb_adr_i == WZTS_ADR_PARAM_B && (&wb_sel_i))
      st_nxt.param_b = wb_dat_i;

    // millisecond count, restarted below on motion
    if (st_r.tick_cnt >= 32'(CYC_PER_MS - 1))
    begin
      st_nxt.tick_cnt = 32'h00000000;
      if (st_r.ms_cnt != 16'hFFFF)
        st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
    end
    else
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h00000001;
    // weight sample and motion tracking
    if (weight_valid)
    begin
      st_nxt.weight = weight_in;
      if (!st_r.mot_seen ||
          abs_diff(weight_in, st_r.mot_ref) > $signed({16'h0000, st_r.motion_band}))
      begin
        st_nxt.mot_ref = weight_in;
        st_nxt.mot_seen = 1'b1;
        st_nxt.ms_cnt = 16'h0000;
        st_nxt.tick_cnt = 32'h00000000;
      end
    end

    // preset tare dropped on return to range unless the policy keeps it
    if (range_return && !st_r.tare_policy[1])
    begin
      st_nxt.tare = 32'sd0;
      st_nxt.tare_active = 1'b0;
    end

    // initial automatic zero, once, when stable inside the band
    if (!st_r.init_done && st_r.initial_zero_band != 24'h000000 && is_stable)
    begin
      st_nxt.init_done = 1'b1;
      if (abs_diff(st_r.weight, st_r.cal_zero) <= $signed({8'h00, st_r.initial_zero_band}))
      begin
        st_nxt.cur_zero = st_r.weight;
        st_nxt.zero_done = 1'b1;
      end
    end

    // command execution
    if (bus_req && wb_we_i && wb_adr_i == WZTS_ADR_CMD && (&wb_sel_i))
    begin
      st_nxt.last_cmd = wb_dat_i[7:0];
      st_nxt.res_done = 1'b1;
      st_nxt.res_err = 1'b0;
      if (query)
      begin
        st_nxt.reply_b = 32'sd0;
        unique case (op)
          WZTS_OP_UNLOCK:
          begin
            st_nxt.reply_tag = WZTS_TAG_E;
            st_nxt.reply_a = {16'h0000, st_r.access_counter};
          end
          WZTS_OP_ZERO_WIN:
          begin
            st_nxt.reply_tag = WZTS_TAG_V;
            st_nxt.reply_a = {12'h000, st_r.zero_window_setting};
          end
          WZTS_OP_TARE_PERS:
          begin
            st_nxt.reply_tag = WZTS_TAG_T;
            st_nxt.reply_a = {31'h00000000, st_r.tare_persist_flag};
          end
          WZTS_OP_ZERO_PERS:
          begin
            st_nxt.reply_tag = WZTS_TAG_Z;
            st_nxt.reply_a = {31'h00000000, st_r.zero_persist_flag};
          end
          WZTS_OP_ABS_ZERO:
          begin
            st_nxt.reply_tag = WZTS_TAG_Z;
            st_nxt.reply_a = st_r.absolute_zero_mvv;
          end
          WZTS_OP_ABS_GAIN:
          begin
            st_nxt.reply_tag = WZTS_TAG_G;
            st_nxt.reply_a = st_r.gain_sig;
            st_nxt.reply_b = st_r.gain_cnt;
          end
          WZTS_OP_MOT_BAND:
          begin
            st_nxt.reply_tag = WZTS_TAG_V;
            st_nxt.reply_a = {16'h0000, st_r.motion_band};
          end
          WZTS_OP_STAB_MS:
          begin
            st_nxt.reply_tag = WZTS_TAG_V;
            st_nxt.reply_a = {16'h0000, st_r.stable_window_ms};
          end
          WZTS_OP_INIT_BAND:
          begin
            st_nxt.reply_tag = WZTS_TAG_V;
            st_nxt.reply_a = {8'h00, st_r.initial_zero_band};
          end
          WZTS_OP_TARE_POL:
          begin
            st_nxt.reply_tag = WZTS_TAG_V;
            st_nxt.reply_a = {30'h00000000, st_r.tare_policy};
          end
          WZTS_OP_CAL_SPAN:
          begin
            st_nxt.reply_tag = WZTS_TAG_V;
            st_nxt.reply_a = st_r.cal_span;
          end
          default: st_nxt.res_err = 1'b1;
        endcase
      end
      else
      begin
        unique case (op)
          WZTS_OP_UNLOCK:
            if (st_r.param_a == $signed({16'h0000, st_r.access_counter}))
              st_nxt.unlocked = 1'b1;
            else
              st_nxt.res_err = 1'b1;
          WZTS_OP_ZERO_FIX:
            if (!st_r.unlocked)
              st_nxt.res_err = 1'b1;
            else
            begin
              st_nxt.cal_zero = st_r.weight;
              st_nxt.cur_zero = st_r.weight;
            end
          WZTS_OP_ZERO_WIN:
            if (!st_r.unlocked || !in_lim(st_r.param_a, 32'sd0, WZTS_ZERO_WIN_MAX))
              st_nxt.res_err = 1'b1;
            else
              st_nxt.zero_window_setting = st_r.param_a[19:0];
          WZTS_OP_INIT_BAND:
            if (!st_r.unlocked || !in_lim(st_r.param_a, 32'sd0, WZTS_INIT_BAND_MAX))
              st_nxt.res_err = 1'b1;
            else
            begin
              st_nxt.initial_zero_band = st_r.param_a[23:0];
              st_nxt.init_done = 1'b0;
            end
          WZTS_OP_TARE_POL:
            if (!st_r.unlocked || !in_lim(st_r.param_a, 32'sd0, 32'sd3))
              st_nxt.res_err = 1'b1;
            else
              st_nxt.tare_policy = st_r.param_a[1:0];
          WZTS_OP_TARE_PERS:
            if (!st_r.unlocked || !in_lim(st_r.param_a, 32'sd0, 32'sd1))
              st_nxt.res_err = 1'b1;
            else
              st_nxt.tare_persist_flag = st_r.param_a[0];
          WZTS_OP_ZERO_PERS:
            if (!st_r.unlocked || !in_lim(st_r.param_a, 32'sd0, 32'sd1))
              st_nxt.res_err = 1'b1;
            else
              st_nxt.zero_persist_flag = st_r.param_a[0];
          WZTS_OP_ABS_ZERO:
            if (!st_r.unlocked ||
                !in_lim(st_r.param_a, -WZTS_ABS_ZERO_LIM, WZTS_ABS_ZERO_LIM))
              st_nxt.res_err = 1'b1;
            else
              st_nxt.absolute_zero_mvv = st_r.param_a;
          WZTS_OP_ABS_GAIN:
            if (!st_r.unlocked)
              st_nxt.res_err = 1'b1;
            else
            begin
              st_nxt.gain_sig = st_r.param_a;
              st_nxt.gain_cnt = st_r.param_b;
            end
          WZTS_OP_SAVE, WZTS_OP_FACTORY:
            if (!st_r.unlocked)
              st_nxt.res_err = 1'b1;
            else
            begin
              if (op == WZTS_OP_FACTORY)
              begin
                st_nxt.gain_sig = WZTS_GAIN_SIG_RST;
                st_nxt.gain_cnt = WZTS_GAIN_CNT_RST;
                st_nxt.absolute_zero_mvv = 32'sd0;
                st_nxt.zero_window_setting = 20'h00000;
                st_nxt.initial_zero_band = 24'h000000;
                st_nxt.tare_policy = 2'h0;
                st_nxt.tare_persist_flag = 1'b0;
                st_nxt.zero_persist_flag = 1'b0;
                st_nxt.motion_band = WZTS_MOTION_BAND_RST;
                st_nxt.stable_window_ms = WZTS_STABLE_MS_RST;
              end
              st_nxt.nv_wr = 1'b1;
              st_nxt.nv_kind = WZTS_NV_GROUP;
              st_nxt.access_counter = st_r.access_counter + 16'h0001;
              st_nxt.unlocked = 1'b0;
            end
          WZTS_OP_CAL_ZERO:
            if (!st_r.unlocked || !is_stable)
              st_nxt.res_err = 1'b1;
            else
            begin
              st_nxt.cal_zero = st_r.weight;
              st_nxt.cur_zero = st_r.weight;
            end
          WZTS_OP_CAL_SPAN:
            if (!st_r.unlocked || !is_stable || !in_lim(st_r.param_a, 32'sd1, WZTS_SPAN_MAX))
              st_nxt.res_err = 1'b1;
            else
              st_nxt.cal_span = st_r.param_a;
          WZTS_OP_SET_ZERO:
            if (!is_stable || abs_diff(st_r.weight, st_r.cal_zero) > zero_win_eff)
              st_nxt.res_err = 1'b1;
            else
            begin
              st_nxt.cur_zero = st_r.weight;
              st_nxt.zero_done = 1'b1;
              st_nxt.nv_wr = st_r.zero_persist_flag;
              st_nxt.nv_kind = WZTS_NV_ZERO;
            end
          WZTS_OP_RST_ZERO:
          begin
            st_nxt.cur_zero = st_r.cal_zero;
            st_nxt.zero_done = 1'b0;
            st_nxt.nv_wr = st_r.zero_persist_flag;
            st_nxt.nv_kind = WZTS_NV_ZERO;
          end
          WZTS_OP_SET_TARE:
            if (!is_stable || (st_r.tare_policy[0] && gross < 0))
              st_nxt.res_err = 1'b1;
            else
            begin
              st_nxt.tare = gross;
              st_nxt.tare_active = 1'b1;
              st_nxt.nv_wr = st_r.tare_persist_flag;
              st_nxt.nv_kind = WZTS_NV_TARE;
            end
          WZTS_OP_RST_TARE:
          begin
            st_nxt.tare = 32'sd0;
            st_nxt.tare_active = 1'b0;
            st_nxt.nv_wr = st_r.tare_persist_flag;
            st_nxt.nv_kind = WZTS_NV_TARE;
          end
          WZTS_OP_MOT_BAND:
            if (!in_lim(st_r.param_a, 32'sd0, WZTS_U16_MAX))
              st_nxt.res_err = 1'b1;
            else
              st_nxt.motion_band = st_r.param_a[15:0];
          WZTS_OP_STAB_MS:
            if (!in_lim(st_r.param_a, 32'sd0, WZTS_U16_MAX))
              st_nxt.res_err = 1'b1;
            else
              st_nxt.stable_window_ms = st_r.param_a[15:0];
          default: st_nxt.res_err = 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.motion_band <= WZTS_MOTION_BAND_RST;
      st_r.stable_window_ms <= WZTS_STABLE_MS_RST;
      st_r.gain_sig <= WZTS_GAIN_SIG_RST;
      st_r.gain_cnt <= WZTS_GAIN_CNT_RST;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  // outputs
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.dat;
  assign nv_wr = st_r.nv_wr;
  assign nv_kind = st_r.nv_kind;
  assign nv_cal_zero = st_r.cal_zero;
  assign nv_cal_span = st_r.cal_span;
  assign nv_zero_window = st_r.zero_window_setting;
  assign nv_tare = st_r.tare;
  assign nv_cur_zero = st_r.cur_zero;
  assign stable = is_stable;
endmodule

// >>> wzts_core_asserts.sv
// Purpose: bus, store and motion checks on the wzts_core ports
// Assumes: clk_en held high and stable window left at its reset value
// Notes: bound into every wzts_core instance
`timescale 1ns/10ps
// ****************************************
// port checker
// ****************************************
module wzts_core_asserts
  import wzts_pkg::*;
#(
  parameter int CYC_PER_MS = WZTS_CYC_PER_MS
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // store and status
  input wire logic nv_wr,
  input wire logic [1:0] nv_kind,
  input wire logic stable
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  int win_cnt_r;
  // cycles since reset, saturating at the default window
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      win_cnt_r <= 0;
    else if (win_cnt_r < 1000 * CYC_PER_MS)
      win_cnt_r <= win_cnt_r + 1;
  end
  // a request that the slave takes
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // answer to a read, one cycle after the take
  sequence s_read_ack;
    wb_ack_o && !$past(wb_we_i);
  endsequence
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_after_take: assert property (s_take |=> wb_ack_o)
    else $error("request not answered after one cycle");
  chk_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  chk_nv_one_pulse: assert property (nv_wr |=> !nv_wr)
    else $error("store pulse longer than one cycle");
  chk_save_writes_group: assert property (nv_wr && nv_kind == WZTS_NV_GROUP |->
    wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == WZTS_ADR_CMD &&
    $past(wb_dat_i[4:0]) inside {WZTS_OP_SAVE, WZTS_OP_FACTORY})
    else $error("group store without a save command");
  chk_status_stable: assert property (s_read_ack ##0 $past(wb_adr_i) == WZTS_ADR_STATUS
    |-> wb_dat_o[0] == $past(stable))
    else $error("status stable bit differs from stable");
  chk_stable_window: assert property (stable |-> win_cnt_r >= 1000 * CYC_PER_MS - 2)
    else $error("stable before the stable window ran out");
  chk_unmapped_zero: assert property (s_read_ack ##0 $past(wb_adr_i) > WZTS_ADR_NET
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped address read not zero");
endmodule
bind wzts_core wzts_core_asserts #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .nv_wr(nv_wr), .nv_kind(nv_kind), .stable(stable));

// >>> wzts_pkg.sv
// Purpose: shared constants and types for the weigher setup and motion block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: command opcodes are written to the command register
package wzts_pkg;
  // register byte addresses
  localparam logic [7:0] WZTS_ADR_CMD = 8'h00;
  localparam logic [7:0] WZTS_ADR_PARAM_A = 8'h04;
  localparam logic [7:0] WZTS_ADR_PARAM_B = 8'h08;
  localparam logic [7:0] WZTS_ADR_STATUS = 8'h0C;
  localparam logic [7:0] WZTS_ADR_REPLY_A = 8'h10;
  localparam logic [7:0] WZTS_ADR_REPLY_B = 8'h14;
  localparam logic [7:0] WZTS_ADR_REPLY_TAG = 8'h18;
  localparam logic [7:0] WZTS_ADR_GROSS = 8'h1C;
  localparam logic [7:0] WZTS_ADR_NET = 8'h20;
  // field positions
  localparam int WZTS_CMD_QUERY_BIT = 7;
  localparam int WZTS_ST_ERR_BIT = 8;
  localparam int WZTS_ST_DONE_BIT = 9;
  localparam int WZTS_ST_UNLOCK_BIT = 10;
  // limits
  localparam logic signed [31:0] WZTS_ZERO_WIN_MAX = 32'sd999999;
  localparam logic signed [31:0] WZTS_INIT_BAND_MAX = 32'sd9999999;
  localparam logic signed [31:0] WZTS_ABS_ZERO_LIM = 32'sd33000;
  localparam logic signed [31:0] WZTS_SPAN_MAX = 32'sd9999999;
  localparam logic signed [31:0] WZTS_U16_MAX = 32'sd65535;
  localparam logic signed [31:0] WZTS_ZERO_WIN_PCT = 32'sd2;
  localparam logic signed [31:0] WZTS_PCT_DIV = 32'sd100;
  // reset values
  localparam logic [15:0] WZTS_MOTION_BAND_RST = 16'h0001;
  localparam logic [15:0] WZTS_STABLE_MS_RST = 16'h03E8;
  localparam logic signed [31:0] WZTS_GAIN_SIG_RST = 32'sd20000;
  localparam logic signed [31:0] WZTS_GAIN_CNT_RST = 32'sd20000;
  // timing
  localparam int WZTS_CLK_HZ = 25000000;
  localparam int WZTS_MS_PER_S = 1000;
  localparam int WZTS_CYC_PER_MS = WZTS_CLK_HZ / WZTS_MS_PER_S;
  // reply prefix letters
  localparam logic [7:0] WZTS_TAG_E = 8'h45;
  localparam logic [7:0] WZTS_TAG_T = 8'h54;
  localparam logic [7:0] WZTS_TAG_Z = 8'h5A;
  localparam logic [7:0] WZTS_TAG_G = 8'h47;
  localparam logic [7:0] WZTS_TAG_V = 8'h56;
  // nonvolatile write kinds
  localparam logic [1:0] WZTS_NV_TARE = 2'h1;
  localparam logic [1:0] WZTS_NV_ZERO = 2'h2;
  localparam logic [1:0] WZTS_NV_GROUP = 2'h3;

  typedef enum logic [4:0] {
    WZTS_OP_NONE = 5'h00,
    WZTS_OP_UNLOCK = 5'h01,
    WZTS_OP_ZERO_FIX = 5'h02,
    WZTS_OP_ZERO_WIN = 5'h03,
    WZTS_OP_INIT_BAND = 5'h04,
    WZTS_OP_TARE_POL = 5'h05,
    WZTS_OP_TARE_PERS = 5'h06,
    WZTS_OP_ZERO_PERS = 5'h07,
    WZTS_OP_ABS_ZERO = 5'h08,
    WZTS_OP_ABS_GAIN = 5'h09,
    WZTS_OP_SAVE = 5'h0A,
    WZTS_OP_CAL_ZERO = 5'h0B,
    WZTS_OP_CAL_SPAN = 5'h0C,
    WZTS_OP_SET_ZERO = 5'h0D,
    WZTS_OP_SET_TARE = 5'h0E,
    WZTS_OP_RST_ZERO = 5'h0F,
    WZTS_OP_RST_TARE = 5'h10,
    WZTS_OP_MOT_BAND = 5'h11,
    WZTS_OP_STAB_MS = 5'h12,
    WZTS_OP_FACTORY = 5'h13
  } wzts_op_t;
endpackage

// >>> wzts_weight_src.sv
// Purpose: load cell sample source feeding the weight port
// Assumes: one sample every PERIOD cycles
// Notes: data is inverted between samples so stale values never look valid
`timescale 1ns/10ps
// ****************************************
// sample source
// ****************************************
module wzts_weight_src
#(
  parameter int PERIOD = 8
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // load asked by the bench
  input wire logic signed [31:0] load,
  // sample stream
  output logic signed [31:0] weight_in,
  output logic weight_valid
);
  int cnt_r;
  // periodic one-cycle sample strobe
  always_ff @(posedge clk_sys)
  begin
    cnt_r <= (sys_rst || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
    weight_valid <= !sys_rst && cnt_r == PERIOD - 1;
    weight_in <= (cnt_r == PERIOD - 1) ? load : ~load;
  end
endmodule
